// *** bst_consts.vh ***
// Purpose: constants for the boundary scan test port
// Assumes: included by every design file of the block
// Notes: Functional notes below give the behaviour in short
`ifndef BST_CONSTS_VH
`define BST_CONSTS_VH

// ------------------------------------------------------------
// Chain shape
// ------------------------------------------------------------
`define BST_IR_W 6
`define BST_ID_W 32
`define BST_N_IN 25
`define BST_N_OUT 5
`define BST_N_BIDI 16
`define BST_CHAIN_W 62

// ------------------------------------------------------------
// Instruction opcodes
// ------------------------------------------------------------
`define BST_OP_EXTEST 6'h00
`define BST_OP_SAMPLE 6'h01
`define BST_OP_IDCODE 6'h02
`define BST_OP_HIGHZ 6'h03
`define BST_OP_CAPT 6'h2d
`define BST_OP_CLAMP 6'h3e
`define BST_OP_BYPASS 6'h3f

// ------------------------------------------------------------
// Data register selection codes
// ------------------------------------------------------------
`define BST_SEL_BYP 2'h0
`define BST_SEL_BSC 2'h1
`define BST_SEL_ID 2'h2

// ------------------------------------------------------------
// TAP controller state codes
// ------------------------------------------------------------
`define BST_ST_TLR 4'h0
`define BST_ST_RTI 4'h1
`define BST_ST_SEL_DR 4'h2
`define BST_ST_CAP_DR 4'h3
`define BST_ST_SH_DR 4'h4
`define BST_ST_EX1_DR 4'h5
`define BST_ST_PAU_DR 4'h6
`define BST_ST_EX2_DR 4'h7
`define BST_ST_UPD_DR 4'h8
`define BST_ST_SEL_IR 4'h9
`define BST_ST_CAP_IR 4'ha
`define BST_ST_SH_IR 4'hb
`define BST_ST_EX1_IR 4'hc
`define BST_ST_PAU_IR 4'hd
`define BST_ST_EX2_IR 4'he
`define BST_ST_UPD_IR 4'hf

`endif

// *** bst_tap_fsm.v ***
// Purpose: sixteen-state TAP controller
// Assumes: step is a one-cycle pulse at each rising test clock edge
// Notes: reset input is already the merge of system and test reset
`include "bst_consts.vh"

module bst_tap_fsm (
  input wire clk_sys, // System clock
  input wire rst_n, // Async reset, low
  input wire step, // Rising test clock pulse
  input wire tms, // Synchronised mode select
  output reg [3:0] state // Current controller state
);

  localparam TLR = `BST_ST_TLR;
  localparam RTI = `BST_ST_RTI;
  localparam SEL_DR = `BST_ST_SEL_DR;
  localparam CAP_DR = `BST_ST_CAP_DR;
  localparam SH_DR = `BST_ST_SH_DR;
  localparam EX1_DR = `BST_ST_EX1_DR;
  localparam PAU_DR = `BST_ST_PAU_DR;
  localparam EX2_DR = `BST_ST_EX2_DR;
  localparam UPD_DR = `BST_ST_UPD_DR;
  localparam SEL_IR = `BST_ST_SEL_IR;
  localparam CAP_IR = `BST_ST_CAP_IR;
  localparam SH_IR = `BST_ST_SH_IR;
  localparam EX1_IR = `BST_ST_EX1_IR;
  localparam PAU_IR = `BST_ST_PAU_IR;
  localparam EX2_IR = `BST_ST_EX2_IR;
  localparam UPD_IR = `BST_ST_UPD_IR;

  reg [3:0] next_state;

  // Standard graph; TMS high five times ends in TLR from anywhere
  always @* begin
    case (state)
      TLR: next_state = tms ? TLR : RTI;
      RTI: next_state = tms ? SEL_DR : RTI;
      SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
      CAP_DR: next_state = tms ? EX1_DR : SH_DR;
      SH_DR: next_state = tms ? EX1_DR : SH_DR;
      EX1_DR: next_state = tms ? UPD_DR : PAU_DR;
      PAU_DR: next_state = tms ? EX2_DR : PAU_DR;
      EX2_DR: next_state = tms ? UPD_DR : SH_DR;
      UPD_DR: next_state = tms ? SEL_DR : RTI;
      SEL_IR: next_state = tms ? TLR : CAP_IR;
      CAP_IR: next_state = tms ? EX1_IR : SH_IR;
      SH_IR: next_state = tms ? EX1_IR : SH_IR;
      EX1_IR: next_state = tms ? UPD_IR : PAU_IR;
      PAU_IR: next_state = tms ? EX2_IR : PAU_IR;
      EX2_IR: next_state = tms ? UPD_IR : SH_IR;
      UPD_IR: next_state = tms ? SEL_DR : RTI;
      default: next_state = TLR;
    endcase
  end

  // Moves only on rising test clock; reset acts without any edge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= TLR;
    end else if (step) begin
      state <= next_state;
    end
  end

endmodule

// *** bst_cell.v ***
// Purpose: one boundary scan cell, capture/shift stage plus update latch
// Assumes: strobes are one-cycle pulses from the test clock edge finder
// Notes: update latch only moves on the falling edge strobe
`include "bst_consts.vh"

module bst_cell (
  input wire clk_sys, // System clock
  input wire rst_n, // Async reset, low
  input wire cap_en, // Capture pulse
  input wire shift_en, // Shift pulse
  input wire upd_en, // Update pulse, falling edge
  input wire cap_in, // Parallel capture value
  input wire scan_in, // From the TDI side
  output reg scan_q, // Toward the TDO side
  output reg upd_q // Latched parallel output
);

  // Capture has priority; the two never coincide in one state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scan_q <= 1'h0;
    end else if (cap_en) begin
      scan_q <= cap_in;
    end else if (shift_en) begin
      scan_q <= scan_in;
    end
  end

  // Written on the Update-DR fall, at least a test clock and a half after the last shift
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      upd_q <= 1'h0;
    end else if (upd_en) begin
      upd_q <= scan_q;
    end
  end

endmodule

// *** bst_tap_top.v ***
// Purpose: test access port with instruction, bypass, ID and boundary registers
// Assumes: test clock far slower than clk_sys, so its edges are found by sampling
// Notes: only DC pins are scanned; clock, strap and test pins carry no cell
`include "bst_consts.vh"

module bst_tap_top #(
  parameter [31:0] ID_VALUE = 32'h00000001 // Arbitrary neutral ID, bit 0 set
) (
  input wire clk_sys, // System clock, 20 MHz
  input wire resetn, // Async system reset, low
  input wire tck, // Test clock pin
  input wire trst_n, // Test reset pin, low
  input wire tms, // Test mode select pin
  input wire tdi, // Test data in pin
  output reg tdo, // Test data out
  output reg tdo_oe, // High while tdo driven
  input wire [`BST_N_IN-1:0] in_pin, // Input-only pads, observed
  input wire [`BST_N_OUT-1:0] out_core, // Core data for output pads
  output reg [`BST_N_OUT-1:0] out_pin, // Output pad data
  output reg [`BST_N_OUT-1:0] out_pin_oe, // Output pad enable
  input wire [`BST_N_BIDI-1:0] bidi_core_out, // Core data for bidir pads
  input wire [`BST_N_BIDI-1:0] bidi_core_oe, // Core enable for bidir pads
  input wire [`BST_N_BIDI-1:0] bidi_pad_in, // Bidir pad levels
  output reg [`BST_N_BIDI-1:0] bidi_pad_out, // Bidir pad data
  output reg [`BST_N_BIDI-1:0] bidi_pad_oe // Bidir pad enable
);

  localparam NI = `BST_N_IN;
  localparam NO = `BST_N_OUT;
  localparam NB = `BST_N_BIDI;
  localparam CW = `BST_CHAIN_W;
  localparam IW = `BST_IR_W;
  localparam DW = `BST_ID_W;
  localparam EN0 = NI + NO; // First bidir enable cell
  localparam DA0 = NI + NO + NB; // First bidir data cell

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------

  // Picks the data register; any unknown opcode lands on bypass
  function [1:0] dr_sel;
    input [IW-1:0] op;
    begin
      case (op)
        `BST_OP_EXTEST: dr_sel = `BST_SEL_BSC;
        `BST_OP_SAMPLE: dr_sel = `BST_SEL_BSC;
        `BST_OP_IDCODE: dr_sel = `BST_SEL_ID;
        default: dr_sel = `BST_SEL_BYP;
      endcase
    end
  endfunction

  // Opcodes that hand the pads to the update latches
  function pins_from_latch;
    input [IW-1:0] op;
    begin
      pins_from_latch = (op == `BST_OP_EXTEST) || (op == `BST_OP_CLAMP);
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ------------------------------------------------------------
  wire tap_rst_n;
  reg tck_m;
  reg tck_s;
  reg tck_d;
  reg tms_m;
  reg tms_s;
  reg tdi_m;
  reg tdi_s;
  reg [NI-1:0] in_m;
  reg [NI-1:0] in_s;
  reg [NB-1:0] bpad_m;
  reg [NB-1:0] bpad_s;
  wire tck_rise;
  wire tck_fall;

  // Either reset drops the port at once, no clock needed
  assign tap_rst_n = resetn & trst_n;

  // Same depth on clock and data keeps TMS/TDI aligned to the edge
  always @(posedge clk_sys or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tck_m <= 1'h0;
      tck_s <= 1'h0;
      tck_d <= 1'h0;
      tms_m <= 1'h1;
      tms_s <= 1'h1;
      tdi_m <= 1'h1;
      tdi_s <= 1'h1;
      in_m <= {NI{1'h0}};
      in_s <= {NI{1'h0}};
      bpad_m <= {NB{1'h0}};
      bpad_s <= {NB{1'h0}};
    end else begin
      tck_m <= tck;
      tck_s <= tck_m;
      tck_d <= tck_s;
      tms_m <= tms;
      tms_s <= tms_m;
      tdi_m <= tdi;
      tdi_s <= tdi_m;
      in_m <= in_pin;
      in_s <= in_m;
      bpad_m <= bidi_pad_in;
      bpad_s <= bpad_m;
    end
  end

  // Edge pulses; TMS/TDI taken on rise only
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // ------------------------------------------------------------
  // Controller
  // ------------------------------------------------------------
  wire [3:0] state;

  bst_tap_fsm bst_tap_fsm_inst (
    .clk_sys(clk_sys),
    .rst_n(tap_rst_n),
    .step(tck_rise),
    .tms(tms_s),
    .state(state)
  );

  wire in_tlr;
  wire cap_dr;
  wire sh_dr;
  wire upd_dr;
  wire cap_ir;
  wire sh_ir;
  wire upd_ir;

  // State decodes used by the action strobes
  assign in_tlr = (state == `BST_ST_TLR);
  assign cap_dr = (state == `BST_ST_CAP_DR);
  assign sh_dr = (state == `BST_ST_SH_DR);
  assign upd_dr = (state == `BST_ST_UPD_DR);
  assign cap_ir = (state == `BST_ST_CAP_IR);
  assign sh_ir = (state == `BST_ST_SH_IR);
  assign upd_ir = (state == `BST_ST_UPD_IR);

  // ------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------
  reg [IW-1:0] ir_shift;
  reg [IW-1:0] ir;
  wire [1:0] sel;
  wire drive_latch;
  wire highz;
  wire extest;

  // Shifter captures fixed pattern, shifts LSB first from TDI
  always @(posedge clk_sys or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_shift <= `BST_OP_CAPT;
    end else if (tck_rise && cap_ir) begin
      ir_shift <= `BST_OP_CAPT;
    end else if (tck_rise && sh_ir) begin
      ir_shift <= {tdi_s, ir_shift[IW-1:1]};
    end
  end

  // Current opcode changes only at Update-IR or in Test-Logic-Reset, so shifting never disturbs pins
  always @(posedge clk_sys or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir <= `BST_OP_IDCODE;
    end else if (in_tlr) begin
      ir <= `BST_OP_IDCODE;
    end else if (tck_fall && upd_ir) begin
      ir <= ir_shift;
    end
  end

  assign sel = dr_sel(ir);
  assign drive_latch = pins_from_latch(ir);
  assign highz = (ir == `BST_OP_HIGHZ);
  assign extest = (ir == `BST_OP_EXTEST);

  // ------------------------------------------------------------
  // Bypass and identification registers
  // ------------------------------------------------------------
  reg byp;
  reg [DW-1:0] id_shift;

  // Bypass is a single bit that always captures zero
  always @(posedge clk_sys or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      byp <= 1'h0;
    end else if (tck_rise && cap_dr) begin
      byp <= 1'h0;
    end else if (tck_rise && sh_dr && sel == `BST_SEL_BYP) begin
      byp <= tdi_s;
    end
  end

  // ID reloads on every capture so repeated reads stay stable
  always @(posedge clk_sys or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_shift <= ID_VALUE;
    end else if (tck_rise && cap_dr) begin
      id_shift <= ID_VALUE;
    end else if (tck_rise && sh_dr && sel == `BST_SEL_ID) begin
      id_shift <= {tdi_s, id_shift[DW-1:1]};
    end
  end

  // ------------------------------------------------------------
  // Boundary chain
  // ------------------------------------------------------------
  wire bsc_sel;
  wire bsc_cap;
  wire bsc_sh;
  wire bsc_upd;
  wire [CW-1:0] cap_v;
  wire [CW-1:0] scan_v;
  wire [CW:0] chain_in;
  wire [CW-1:0] upd_v;
  wire [NB-1:0] bidi_cap;

  // Cells act only when the chain is the chosen register
  assign bsc_sel = (sel == `BST_SEL_BSC);
  assign bsc_cap = tck_rise & cap_dr & bsc_sel;
  assign bsc_sh = tck_rise & sh_dr & bsc_sel;
  assign bsc_upd = tck_fall & upd_dr & bsc_sel;

  // Bidir capture: core data when pad enabled outside EXTEST, else pad
  assign bidi_cap = (bidi_pad_oe & {NB{~extest}} & bidi_core_out) |
                    (~(bidi_pad_oe & {NB{~extest}}) & bpad_s);

  // Order from TDO: inputs, outputs, bidir enables, bidir data
  assign cap_v = {bidi_cap, bidi_core_oe, out_core, in_s};
  assign chain_in[CW] = tdi_s;

  genvar k;
  generate
    for (k = 0; k < CW; k = k + 1) begin : g_cell
      bst_cell bst_cell_inst (
        .clk_sys(clk_sys),
        .rst_n(tap_rst_n),
        .cap_en(bsc_cap),
        .shift_en(bsc_sh),
        .upd_en(bsc_upd),
        .cap_in(cap_v[k]),
        .scan_in(chain_in[k+1]),
        .scan_q(scan_v[k]),
        .upd_q(upd_v[k])
      );
      assign chain_in[k] = scan_v[k];
    end
  endgenerate

  // ------------------------------------------------------------
  // Pad drive
  // ------------------------------------------------------------
  // Input cell latches (upd_v below NI) are never routed to any pad
  always @(posedge clk_sys or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      out_pin <= {NO{1'h0}};
      out_pin_oe <= {NO{1'h0}};
      bidi_pad_out <= {NB{1'h0}};
      bidi_pad_oe <= {NB{1'h0}};
    end else if (highz) begin
      out_pin <= out_core;
      out_pin_oe <= {NO{1'h0}};
      bidi_pad_out <= bidi_core_out;
      bidi_pad_oe <= {NB{1'h0}};
    end else if (drive_latch) begin
      out_pin <= upd_v[NI+NO-1:NI];
      out_pin_oe <= {NO{1'h1}};
      bidi_pad_out <= upd_v[DA0+NB-1:DA0];
      bidi_pad_oe <= upd_v[EN0+NB-1:EN0];
    end else begin
      out_pin <= out_core;
      out_pin_oe <= {NO{1'h1}};
      bidi_pad_out <= bidi_core_out;
      bidi_pad_oe <= bidi_core_oe;
    end
  end

  // ------------------------------------------------------------
  // Serial output
  // ------------------------------------------------------------
  reg next_tdo;

  // Pick the LSB of whichever register is in the path
  always @* begin
    if (sh_ir) begin
      next_tdo = ir_shift[0];
    end else begin
      case (sel)
        `BST_SEL_BSC: next_tdo = scan_v[0];
        `BST_SEL_ID: next_tdo = id_shift[0];
        default: next_tdo = byp;
      endcase
    end
  end

  // Updated on the fall so the tester has a half period of setup
  always @(posedge clk_sys or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (tck_fall) begin
      tdo <= next_tdo;
      tdo_oe <= sh_dr | sh_ir;
    end
  end

endmodule

// *** bst_tap_checker.sv ***
// Purpose: port-level timing checks of the serial test port
// Assumes: tester keeps tck low at least 4 system clocks per half period
// Notes: pad and tdo changes are timed from the last tck fall seen on the pin
`include "bst_consts.vh"

module bst_tap_checker (
  input wire clk_sys, // System clock
  input wire resetn, // System reset, low
  input wire tck, // Test clock pin
  input wire trst_n, // Test reset pin, low
  input wire tms, // Mode select pin
  input wire tdo, // Serial out
  input wire tdo_oe, // Serial out enable
  input wire [`BST_N_OUT-1:0] out_pin_oe, // Output pad enable
  input wire [`BST_N_BIDI-1:0] bidi_core_oe, // Core bidir enable
  input wire [`BST_N_BIDI-1:0] bidi_pad_oe // Bidir pad enable
);
  timeunit 1ns;
  timeprecision 1ns;
  wire rst_all_n = resetn & trst_n;
  logic tck_q;
  logic last_tms;
  logic [2:0] ones;
  logic [3:0] fall_age;

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Release counts as a fall, since pads reload right after it
  always @(posedge clk_sys or negedge rst_all_n) begin
    if (!rst_all_n) begin
      tck_q <= 1'b0;
      last_tms <= 1'b1;
      ones <= 3'h0;
      fall_age <= 4'h3;
    end else begin
      tck_q <= tck;
      fall_age <= (tck_q && !tck) ? 4'h0 : (fall_age == 4'hf ? fall_age : fall_age + 4'h1);
      if (tck && !tck_q) begin
        last_tms <= tms;
        ones <= !tms ? 3'h0 : (ones == 3'h7 ? ones : ones + 3'h1);
      end
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn || !trst_n);
  sequence s_trst_held;
    !trst_n [*2];
  endsequence
  property p_tdo_fall;
    $changed(tdo) |-> fall_age inside {[2:4]};
  endproperty
  property p_oe_fall;
    $changed(tdo_oe) |-> fall_age inside {[2:4]};
  endproperty
  property p_oe_enter;
    $rose(tdo_oe) |-> !last_tms;
  endproperty
  property p_oe_leave;
    $fell(tdo_oe) |-> last_tms;
  endproperty
  property p_trst;
    disable iff (!resetn)
    s_trst_held |-> !tdo_oe && !tdo && out_pin_oe == '0 && bidi_pad_oe == '0;
  endproperty
  property p_five_ones;
    ones >= 3'h5 |-> !tdo_oe;
  endproperty
  property p_pad_upd;
    $changed(out_pin_oe) |-> fall_age inside {[3:5]};
  endproperty
  property p_bidi_upd;
    $changed(bidi_pad_oe) && $past(bidi_core_oe) == $past(bidi_core_oe, 2)
      |-> fall_age inside {[3:5]};
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a tck fall");
  a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe moved away from a fall");
  a_oe_enter: assert property (p_oe_enter) else $error("tdo_oe rose without tms low");
  a_oe_leave: assert property (p_oe_leave) else $error("tdo_oe fell without tms high");
  a_trst: assert property (p_trst) else $error("outputs active in test reset");
  a_five_ones: assert property (p_five_ones) else $error("tdo driven after five ones");
  a_pad_upd: assert property (p_pad_upd) else $error("pad enable moved off a fall");
  a_bidi_upd: assert property (p_bidi_upd) else $error("bidir oe moved off a fall");
endmodule

// *** bst_tester.sv ***
// Purpose: board tester model driving the serial test port
// Assumes: tck idles low between frames, 8 system clocks a period
// Notes: tdi rests at its pull-up level outside shifting
module bst_tester (
  input wire clk_sys, // System clock
  output logic tck, // Test clock
  output logic tms, // Mode select
  output logic tdi, // Serial data to device
  input wire tdo, // Serial data from device
  input wire tdo_oe // Device drives tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  int stretch = 0; // Extra low time for a slow tester
  logic oe_ok;
  logic last_oe;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // ------------------------------------------------------------
  // One test clock period
  // ------------------------------------------------------------
  // Sample late in the high phase, clear of the output lag
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms <= m;
    tdi <= d;
    repeat (4 + stretch) @(posedge clk_sys);
    tck <= 1'b1;
    repeat (3) @(posedge clk_sys);
    q = tdo;
    oe = tdo_oe;
    @(posedge clk_sys);
    tck <= 1'b0;
  endtask

  task automatic to_idle();
    logic q, oe;
    step(1'b0, 1'b1, q, oe);
  endtask

  task automatic five_ones();
    logic q, oe;
    repeat (5) step(1'b1, 1'b1, q, oe);
  endtask

  // Idle -> capture -> shift n bits, LSB first -> update -> idle
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
                      output logic [63:0] dout);
    logic q, oe;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b1, q, oe);
    if (ir) step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, oe);
      dout[i] = q;
      if (oe !== 1'b1) oe_ok = 1'b0;
    end
    step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    last_oe = oe;
  endtask
endmodule

// *** boundary_scan_tap_bench.sv ***
// Purpose: self-checking bench for the test access port
// Assumes: tester model owns tck, tms and tdi
// Notes: expected scans are built from the fixed pad stimulus below
module boundary_scan_tap_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ID_VAL = 32'h00a55a01; // Arbitrary, bit 0 set
  localparam logic [24:0] IN_V = 25'h1a2b3c4;
  localparam logic [4:0] OC_V = 5'h0b;
  localparam logic [15:0] BCO = 16'h1234;
  localparam logic [15:0] BOE = 16'h00ff;
  localparam logic [15:0] BPI = 16'hbeef;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic trst_n = 1'b1;
  logic [24:0] in_pin = IN_V;
  logic [4:0] out_core = OC_V;
  logic [15:0] bidi_core_out = BCO;
  logic [15:0] bidi_core_oe = BOE;
  logic [15:0] bidi_pad_in = BPI;
  wire tck, tms, tdi, tdo, tdo_oe;
  wire [4:0] out_pin, out_pin_oe;
  wire [15:0] bidi_pad_out, bidi_pad_oe;
  int fails = 0;
  int comparisons = 0;

  always #25 clk_sys = ~clk_sys;

  bst_tap_top #(.ID_VALUE(ID_VAL)) bst_tap_top_inst (.clk_sys(clk_sys), .resetn(resetn),
    .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .in_pin(in_pin), .out_core(out_core), .out_pin(out_pin), .out_pin_oe(out_pin_oe),
    .bidi_core_out(bidi_core_out), .bidi_core_oe(bidi_core_oe), .bidi_pad_in(bidi_pad_in),
    .bidi_pad_out(bidi_pad_out), .bidi_pad_oe(bidi_pad_oe));
  bst_tester bst_tester_inst (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ir(input logic [5:0] op, output logic [5:0] cap);
    logic [63:0] w;
    bst_tester_inst.scan(1'b1, {58'h0, op}, 6, w);
    cap = w[5:0];
  endtask

  // Always 62 bits, so shorter registers show the shifted-in tail
  task automatic dr(input logic [61:0] d, output logic [61:0] q);
    logic [63:0] w;
    bst_tester_inst.scan(1'b0, {2'h0, d}, 62, w);
    q = w[61:0];
  endtask

  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_id();
    logic [61:0] q;
    dr(62'h0, q);
    check(q, {30'h0, ID_VAL});
    check(bst_tester_inst.oe_ok, 1'b1);
    check(bst_tester_inst.last_oe, 1'b0);
    $display("test id done");
  endtask

  task automatic t_bypass();
    logic [5:0] ops [5] = '{6'h3f, 6'h10, 6'h03, 6'h3e, 6'h2e};
    logic [61:0] d = 62'h1555555555555555;
    logic [5:0] cap;
    logic [61:0] q;
    foreach (ops[k]) begin
      ir(ops[k], cap);
      check(cap, 6'h2d);
      dr(d, q);
      check(q, {d[60:0], 1'b0});
      if (ops[k] == 6'h03) check({out_pin_oe, bidi_pad_oe}, 21'h0);
      if (ops[k] == 6'h3e) check({bidi_pad_out, bidi_pad_oe, out_pin, out_pin_oe}, 42'h1f);
      if (ops[k] == 6'h3f) check({out_pin, out_pin_oe, bidi_pad_oe}, {OC_V, 5'h1f, BOE});
    end
    $display("test bypass done");
  endtask

  task automatic t_extest();
    logic [5:0] cap;
    logic [61:0] q;
    ir(6'h01, cap);
    dr({16'h5a5a, 16'hf0f0, 5'h15, 25'h0}, q);
    check(q, {(BCO & BOE) | (BPI & ~BOE), BOE, OC_V, IN_V});
    check(out_pin, OC_V);
    ir(6'h00, cap);
    check({bidi_pad_out, bidi_pad_oe, out_pin, out_pin_oe},
          {16'h5a5a, 16'hf0f0, 5'h15, 5'h1f});
    bidi_pad_in <= 16'h0ff0;
    dr({16'ha5a5, 16'h0ff0, 5'h0a, 25'h0}, q);
    check(q[61:46], 16'h0ff0);
    check(q[24:0], IN_V);
    check({bidi_pad_out, bidi_pad_oe, out_pin}, {16'ha5a5, 16'h0ff0, 5'h0a});
    $display("test extest done");
  endtask

  // Test reset in mid-shift with the test clock stopped
  task automatic t_trst();
    logic q, oe;
    logic [61:0] r;
    bst_tester_inst.step(1'b1, 1'b1, q, oe);
    bst_tester_inst.step(1'b1, 1'b1, q, oe);
    bst_tester_inst.step(1'b0, 1'b1, q, oe);
    repeat (3) bst_tester_inst.step(1'b0, 1'b0, q, oe);
    check(oe, 1'b1);
    trst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({tdo_oe, out_pin_oe}, 6'h0);
    trst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bst_tester_inst.to_idle();
    dr(62'h0, r);
    check(r, {30'h0, ID_VAL});
    $display("test trst done");
  endtask

  // Slow tester leaves a data shift through five ones
  task automatic t_tms();
    logic [5:0] cap;
    logic [61:0] r;
    logic q, oe;
    bst_tester_inst.stretch = 12;
    ir(6'h3f, cap);
    bst_tester_inst.step(1'b1, 1'b1, q, oe);
    bst_tester_inst.step(1'b0, 1'b1, q, oe);
    bst_tester_inst.step(1'b0, 1'b0, q, oe);
    bst_tester_inst.five_ones();
    bst_tester_inst.to_idle();
    dr(62'h0, r);
    check(r, {30'h0, ID_VAL});
    bst_tester_inst.stretch = 0;
    $display("test tms reset done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    bst_tester_inst.to_idle();
    t_id();
    t_bypass();
    t_extest();
    t_trst();
    t_tms();
    test_done();
  end

  // About eight times the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    test_done();
  end
endmodule

bind bst_tap_top bst_tap_checker bst_tap_checker_inst (.clk_sys(clk_sys), .resetn(resetn),
  .tck(tck), .trst_n(trst_n), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
  .out_pin_oe(out_pin_oe), .bidi_core_oe(bidi_core_oe), .bidi_pad_oe(bidi_pad_oe));
